// File: logic/octal_uart_global_control.v
// device-wide configuration and interrupt-gathering registers of an eight-channel uart
`timescale 1ns/1ps
`default_nettype none
`include "uart_global_defines.vh"

// Contract
// - pending register, one bit per channel
// - three registers pack 3-bit codes per channel
// - code zero means none or wake-up
// - code 001 receive data or line status
// - 010 receive time-out, 011 transmit ready
// - 100 modem/flow events; 101,110 never produced
// - code 111 timer time-out, channel 0 only
// - reading timer register clears timer interrupt
// - low nibble commands: irq enable/disable, start/stop/reset
// - commands select one-shot/retrigger, clock source
// - write-one pulses self-clearing per-channel reset
// - sleep enable register, reset to zero
// - read-only revision number register
// - identifier chosen by bonding option input
// - broadcast bit applies channel writes everywhere
module octal_uart_global_control #(
    parameter       CHANNELS      = 8,
    parameter [7:0] REVISION      = 8'h01, // arbitrary value
    parameter [7:0] ID_OPTION_LOW = 8'h5a, // arbitrary value
    parameter [7:0] ID_OPTION_HIGH = 8'h5b // arbitrary value
) (
    input  wire                clk_i,
    input  wire                rst_i,
    input  wire [7:0]          addr_i,
    input  wire [7:0]          wdata_i,
    input  wire                wr_i,
    input  wire                rd_i,
    output reg  [7:0]          rdata_o,
    input  wire [CHANNELS-1:0] receive_data_ready_i,
    input  wire [CHANNELS-1:0] rx_timeout_i,
    input  wire [CHANNELS-1:0] transmit_ready_i,
    input  wire [CHANNELS-1:0] modem_event_i,
    input  wire                timer_expired_i,
    input  wire                bonding_option_input_i,
    output reg  [CHANNELS-1:0] channel_reset_o,
    output reg  [CHANNELS-1:0] channel_sleep_enable_o,
    output reg                 broadcast_write_o,
    output reg                 timer_irq_enable_o,
    output reg                 timer_run_o,
    output reg                 timer_retrigger_o,
    output reg                 timer_clk_external_o,
    output reg                 timer_restart_o,
    output wire                timer_irq_o
);

    // =========================================================
    // input synchronisers for pins from outside the clock domain
    reg [CHANNELS-1:0] rxd_s1, rxd_s2;
    reg [CHANNELS-1:0] rxt_s1, rxt_s2;
    reg [CHANNELS-1:0] txr_s1, txr_s2;
    reg [CHANNELS-1:0] mod_s1, mod_s2;
    reg                tmr_s1, tmr_s2;
    reg                bonding_option_input_s1, bonding_option_input_s2;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rxd_s1  <= {CHANNELS{1'b0}};
            rxd_s2  <= {CHANNELS{1'b0}};
            rxt_s1  <= {CHANNELS{1'b0}};
            rxt_s2  <= {CHANNELS{1'b0}};
            txr_s1  <= {CHANNELS{1'b0}};
            txr_s2  <= {CHANNELS{1'b0}};
            mod_s1  <= {CHANNELS{1'b0}};
            mod_s2  <= {CHANNELS{1'b0}};
            tmr_s1  <= 1'b0;
            tmr_s2  <= 1'b0;
            bonding_option_input_s1 <= 1'b0;
            bonding_option_input_s2 <= 1'b0;
        end else begin
            rxd_s1  <= receive_data_ready_i;
            rxd_s2  <= rxd_s1;
            rxt_s1  <= rx_timeout_i;
            rxt_s2  <= rxt_s1;
            txr_s1  <= transmit_ready_i;
            txr_s2  <= txr_s1;
            mod_s1  <= modem_event_i;
            mod_s2  <= mod_s1;
            tmr_s1  <= timer_expired_i;
            tmr_s2  <= tmr_s1;
            bonding_option_input_s1 <= bonding_option_input_i;
            bonding_option_input_s2 <= bonding_option_input_s1;
        end
    end

    // =========================================================
    // timer time-out flag: set on rising edge while the timer irq is enabled, cleared by reading the timer register
    reg  tmr_prev;
    reg  timer_flag;
    wire timer_rise;
    wire timer_read;

    assign timer_rise = tmr_s2 & ~tmr_prev;
    assign timer_read = rd_i & (addr_i == `ADDR_TIMER_COMMAND);

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmr_prev   <= 1'b0;
            timer_flag <= 1'b0;
        end else begin
            tmr_prev <= tmr_s2;
            if (timer_rise & timer_irq_enable_o) begin
                timer_flag <= 1'b1; // set wins over a clearing read
            end else if (timer_read) begin
                timer_flag <= 1'b0;
            end
        end
    end

    assign timer_irq_o = timer_flag;

    // =========================================================
    // per-channel source codes and pending bits
    wire [3*CHANNELS-1:0] codes;
    wire [CHANNELS-1:0]   pending;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
            source_encoder u_enc (
                .rx_data_i    (rxd_s2[ch]),
                .rx_timeout_i (rxt_s2[ch]),
                .tx_ready_i   (txr_s2[ch]),
                .modem_i      (mod_s2[ch]),
                .timer_i      ((ch == 0) ? timer_flag : 1'b0),
                .code_o       (codes[3*ch +: 3])
            );
            assign pending[ch] = |codes[3*ch +: 3];
        end
    endgenerate

    // 24-bit packed code field, channel 0 in the lowest bits
    wire [23:0] code_field;
    assign code_field = codes[23:0];

    // =========================================================
    // timer command decode
    wire       cmd_write;
    wire [3:0] cmd;
    assign cmd_write = wr_i & (addr_i == `ADDR_TIMER_COMMAND);
    assign cmd       = wdata_i[3:0];

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            timer_irq_enable_o   <= 1'b0;
            timer_run_o          <= 1'b0;
            timer_retrigger_o    <= 1'b0;
            timer_clk_external_o <= 1'b0;
            timer_restart_o      <= 1'b0;
        end else begin
            timer_restart_o <= 1'b0;
            if (cmd_write) begin
                case (cmd)
                    `CMD_IRQ_ENABLE:   timer_irq_enable_o   <= 1'b1;
                    `CMD_IRQ_DISABLE:  timer_irq_enable_o   <= 1'b0;
                    `CMD_ONE_SHOT:     timer_retrigger_o    <= 1'b0;
                    `CMD_RETRIGGER:    timer_retrigger_o    <= 1'b1;
                    `CMD_CLK_INTERNAL: timer_clk_external_o <= 1'b0;
                    `CMD_CLK_EXTERNAL: timer_clk_external_o <= 1'b1;
                    `CMD_START:        timer_run_o          <= 1'b1;
                    `CMD_STOP:         timer_run_o          <= 1'b0;
                    `CMD_RESET: begin
                        timer_run_o     <= 1'b0;
                        timer_restart_o <= 1'b1;
                    end
                    default: ; // reserved codes are ignored
                endcase
            end
        end
    end

    // =========================================================
    // control registers: channel reset pulse, sleep, broadcast
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            channel_reset_o        <= {CHANNELS{1'b0}};
            channel_sleep_enable_o <= `SLEEP_RESET;
            broadcast_write_o      <= 1'b0;
        end else begin
            if (wr_i & (addr_i == `ADDR_CHANNEL_RESET)) begin
                channel_reset_o <= wdata_i[CHANNELS-1:0];
            end else begin
                channel_reset_o <= {CHANNELS{1'b0}};
            end
            if (wr_i & (addr_i == `ADDR_SLEEP_ENABLE)) begin
                channel_sleep_enable_o <= wdata_i[CHANNELS-1:0];
            end
            if (wr_i & (addr_i == `ADDR_BROADCAST)) begin
                broadcast_write_o <= wdata_i[`BROADCAST_BIT];
            end
        end
    end

    // =========================================================
    // timer register readback, reserved upper nibble reads zero
    wire [7:0] timer_status;
    assign timer_status = {4'h0, timer_clk_external_o, timer_retrigger_o,
                           timer_run_o, timer_irq_enable_o};

    // =========================================================
    // read data, registered on the read strobe
    reg [7:0] next_rdata;

    always @* begin
        if (addr_i == `ADDR_GLOBAL_PENDING) begin
            next_rdata = pending[7:0];
        end else if (addr_i == `ADDR_SOURCE_LOW) begin
            next_rdata = code_field[7:0];
        end else if (addr_i == `ADDR_SOURCE_MID) begin
            next_rdata = code_field[15:8];
        end else if (addr_i == `ADDR_SOURCE_HIGH) begin
            next_rdata = code_field[23:16];
        end else if (addr_i == `ADDR_TIMER_COMMAND) begin
            next_rdata = timer_status;
        end else if (addr_i == `ADDR_SLEEP_ENABLE) begin
            next_rdata = channel_sleep_enable_o;
        end else if (addr_i == `ADDR_REVISION) begin
            next_rdata = REVISION;
        end else if (addr_i == `ADDR_IDENTIFIER) begin
            next_rdata = bonding_option_input_s2 ? ID_OPTION_HIGH : ID_OPTION_LOW;
        end else if (addr_i == `ADDR_BROADCAST) begin
            next_rdata = {7'h00, broadcast_write_o};
        end else begin
            next_rdata = 8'h00;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end
    end

endmodule // octal_uart_global_control

`default_nettype wire

// File: logic/uart_global_defines.vh
// register map, field positions and reset values of the global control block
`ifndef UART_GLOBAL_DEFINES_VH
`define UART_GLOBAL_DEFINES_VH

`define ADDR_GLOBAL_PENDING    8'h80
`define ADDR_SOURCE_LOW        8'h81
`define ADDR_SOURCE_MID        8'h82
`define ADDR_SOURCE_HIGH       8'h83
`define ADDR_TIMER_COMMAND     8'h84
`define ADDR_CHANNEL_RESET     8'h88
`define ADDR_RESERVED_SLOT     8'h89
`define ADDR_SLEEP_ENABLE      8'h8b
`define ADDR_REVISION          8'h8c
`define ADDR_IDENTIFIER        8'h8d
`define ADDR_BROADCAST         8'h8e

`define SLEEP_RESET            8'h00
`define BROADCAST_RESET        8'h00
`define BROADCAST_BIT          0

`define TIMER_CLK_SEL_BIT      3
`define TIMER_MODE_BIT         2
`define TIMER_RUN_BIT          1
`define TIMER_IRQ_EN_BIT       0

`define CMD_IRQ_ENABLE         4'h1
`define CMD_IRQ_DISABLE        4'h2
`define CMD_ONE_SHOT           4'h3
`define CMD_RETRIGGER          4'h4
`define CMD_CLK_INTERNAL       4'h5
`define CMD_CLK_EXTERNAL       4'h6
`define CMD_START              4'h9
`define CMD_STOP               4'ha
`define CMD_RESET              4'hb

`define SRC_NONE               3'h0
`define SRC_RX_DATA            3'h1
`define SRC_RX_TIMEOUT         3'h2
`define SRC_TX_READY           3'h3
`define SRC_MODEM              3'h4
`define SRC_TIMER              3'h7

`endif

// File: logic/source_encoder.v
// per-channel priority encoder of interrupt causes into a 3-bit code
`timescale 1ns/1ps
`default_nettype none
`include "uart_global_defines.vh"

module source_encoder (
    input  wire       rx_data_i,
    input  wire       rx_timeout_i,
    input  wire       tx_ready_i,
    input  wire       modem_i,
    input  wire       timer_i,
    output reg  [2:0] code_o
);
    // =========================================================
    // priority: lowest number wins, zero when nothing pending
    always @* begin
        if (rx_data_i) begin
            code_o = `SRC_RX_DATA;
        end else if (rx_timeout_i) begin
            code_o = `SRC_RX_TIMEOUT;
        end else if (tx_ready_i) begin
            code_o = `SRC_TX_READY;
        end else if (modem_i) begin
            code_o = `SRC_MODEM;
        end else if (timer_i) begin
            code_o = `SRC_TIMER;
        end else begin
            code_o = `SRC_NONE;
        end
    end
endmodule // source_encoder

`default_nettype wire

// File: tb/octal_uart_global_control_props.sv
// assertions on the ports of the global control block
`timescale 1ns/1ps
`default_nettype none
module octal_uart_global_control_props #(
    parameter CHANNELS = 8
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic [7:0]          addr_i,
    input wire logic [7:0]          wdata_i,
    input wire logic                wr_i,
    input wire logic                rd_i,
    input wire logic [7:0]          rdata_o,
    input wire logic [CHANNELS-1:0] channel_reset_o,
    input wire logic [CHANNELS-1:0] channel_sleep_enable_o,
    input wire logic                broadcast_write_o,
    input wire logic                timer_irq_enable_o,
    input wire logic                timer_retrigger_o,
    input wire logic                timer_restart_o,
    input wire logic                timer_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic tw = wr_i && addr_i == 8'h84;
    wire logic cw = wr_i && addr_i == 8'h88;
    property p_rst_pulse; cw |=> channel_reset_o == $past(wdata_i); endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("bad reset pulse");
    property p_rst_cause; channel_reset_o != '0 |-> $past(cw); endproperty
    a_rst_cause: assert property (p_rst_cause) else $error("stray reset pulse");
    property p_sleep;
        wr_i && addr_i == 8'h8b |=> channel_sleep_enable_o == $past(wdata_i);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep enables wrong");
    property p_bcast; wr_i && addr_i == 8'h8e |=> broadcast_write_o == $past(wdata_i[0]); endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast bit wrong");
    property p_irq_on; tw && wdata_i[3:0] == 4'h1 |=> timer_irq_enable_o; endproperty
    a_irq_on: assert property (p_irq_on) else $error("timer irq not enabled");
    property p_restart; timer_restart_o |-> $past(tw && wdata_i[3:0] == 4'hb); endproperty
    a_restart: assert property (p_restart) else $error("stray timer restart");
    property p_retrig; tw && wdata_i[3:0] == 4'h4 |=> timer_retrigger_o; endproperty
    a_retrig: assert property (p_retrig) else $error("retrigger not selected");
    property p_ack; rd_i && addr_i == 8'h84 && !timer_irq_enable_o |=> !timer_irq_o; endproperty
    a_ack: assert property (p_ack) else $error("timer flag not cleared");
    property p_rsvd; rd_i && addr_i == 8'h89 |=> rdata_o == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved slot not zero");
    c_ack: cover property (rd_i && addr_i == 8'h84 && timer_irq_o);
    c_restart: cover property (timer_restart_o);
    c_bcast: cover property ($rose(broadcast_write_o));
endmodule // octal_uart_global_control_props
bind octal_uart_global_control octal_uart_global_control_props #(.CHANNELS(CHANNELS)) props_inst (
    .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .channel_reset_o,
    .channel_sleep_enable_o, .broadcast_write_o, .timer_irq_enable_o, .timer_retrigger_o,
    .timer_restart_o, .timer_irq_o
);
`default_nettype wire

// File: tb/host_model.sv
// host processor model issuing register strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_o,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       wr_o,
    output var  logic       rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // called at a falling edge; each strobe lasts one clock
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        // wait one falling edge only if a strobe is still high, which no task leaves behind, so back-to-back calls get no idle edge
        if (wr_o || rd_o) @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        if (wr_o || rd_o) @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        d = rdata_o;
    endtask
    task automatic ack(output logic [7:0] d);
        rd(8'h84, d);
    endtask
endmodule // host_model
`default_nettype wire

// File: tb/octal_uart_global_control_bench.sv
// self-checking bench of the global control block
`timescale 1ns/1ps
`default_nettype none
module octal_uart_global_control_bench;
    localparam logic [7:0] REV = 8'h01; // arbitrary value
    localparam logic [7:0] ID0 = 8'h5a; // arbitrary value
    localparam logic [7:0] ID1 = 8'h5b; // arbitrary value
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  rx = 8'h00, to = 8'h00, tx = 8'h00, md = 8'h00, d, q;
    logic        tmr = 1'b0, bonding_option_input = 1'b0;
    logic [23:0] codes;
    logic [7:0]  pend;
    logic [3:0]  st, c;
    logic [7:0]  ra [11] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h89, 8'h8b, 8'h8c, 8'h8d,
                             8'h8e, 8'h90};
    logic [3:0]  cmds [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha, 4'hb};
    wire  [7:0]  addr_i, wdata_i, rdata_o, channel_reset_o, channel_sleep_enable_o;
    wire         wr_i, rd_i, broadcast_write_o, timer_irq_enable_o, timer_run_o;
    wire         timer_retrigger_o, timer_clk_external_o, timer_restart_o, timer_irq_o;
    int          seed = 32'hbfe6b01e;
    int          failures = 0, checked = 0, cycles = 0;
    host_model host (.clk_i, .rdata_o, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    octal_uart_global_control #(.REVISION(REV), .ID_OPTION_LOW(ID0), .ID_OPTION_HIGH(ID1))
    octal_uart_global_control_inst (
        .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .receive_data_ready_i(rx), .rx_timeout_i(to), .transmit_ready_i(tx),
        .modem_event_i(md), .timer_expired_i(tmr), .bonding_option_input_i(bonding_option_input),
        .channel_reset_o, .channel_sleep_enable_o, .broadcast_write_o, .timer_irq_enable_o,
        .timer_run_o, .timer_retrigger_o, .timer_clk_external_o, .timer_restart_o, .timer_irq_o
    );
    initial forever #50 clk_i = ~clk_i;
    function automatic logic [2:0] code_of(input logic a, b, e, m);
        code_of = a ? 3'h1 : b ? 3'h2 : e ? 3'h3 : m ? 3'h4 : 3'h0;
    endfunction
    // timer state {external clock, retrigger, running, irq enable}
    function automatic logic [3:0] step(input logic [3:0] s, input logic [3:0] k);
        step = s;
        case (k)
            4'h1: step[0] = 1'b1;
            4'h2: step[0] = 1'b0;
            4'h3: step[2] = 1'b0;
            4'h4: step[2] = 1'b1;
            4'h5: step[3] = 1'b0;
            4'h6: step[3] = 1'b1;
            4'h9: step[1] = 1'b1;
            default: step[1] = 1'b0;
        endcase
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        foreach (ra[i]) begin
            host.rd(ra[i], d);
            check(d, ra[i] == 8'h8c ? REV : ra[i] == 8'h8d ? ID0 : 8'h00);
        end
        for (int k = 0; k < 24; k++) begin
            {rx, to, tx, md} = k == 0 ? 32'hffff_ffff : k == 1 ? 32'h0 : $random(seed);
            repeat (3) @(negedge clk_i);
            for (int n = 0; n < 8; n++) begin
                codes[3*n +: 3] = code_of(rx[n], to[n], tx[n], md[n]);
                pend[n] = codes[3*n +: 3] != 3'h0;
            end
            host.rd(8'h80, d);
            check(d, pend);
            for (int r = 0; r < 3; r++) begin
                host.rd(8'(8'h81 + r), d);
                check(d, codes[8*r +: 8]);
            end
        end
        {rx, to, tx, md} = 32'h0000_0002;
        host.wr(8'h84, 8'h01);
        tmr = 1'b1;
        repeat (5) @(negedge clk_i);
        check({7'h0, timer_irq_o}, 8'h01);
        host.rd(8'h81, d);
        check(d, 8'h27);
        host.ack(d);
        check(d, 8'h01);
        check({7'h0, timer_irq_o}, 8'h00);
        tmr = 1'b0;
        md = 8'h00;
        st = 4'h1;
        for (int k = 0; k < 30; k++) begin
            c = k < 9 ? cmds[k] : cmds[{$random(seed)} % 9];
            host.wr(8'h84, {4'(k), c});
            st = step(st, c);
            host.rd(8'h84, d);
            check(d, {4'h0, st});
        end
        d = $random(seed);
        host.wr(8'h88, d);
        check(channel_reset_o, d);
        @(negedge clk_i);
        check(channel_reset_o, 8'h00);
        host.wr(8'h8b, d);
        host.rd(8'h8b, q);
        check(q, d);
        host.wr(8'h8e, 8'hff);
        host.rd(8'h8e, q);
        check(q, {7'h0, broadcast_write_o});
        check(q, 8'h01);
        host.wr(8'h89, 8'hff);
        host.rd(8'h89, q);
        check(q, 8'h00);
        bonding_option_input = 1'b1;
        repeat (3) @(negedge clk_i);
        host.rd(8'h8d, q);
        check(q, ID1);
        wrap_up();
    end
endmodule // octal_uart_global_control_bench
`default_nettype wire
